// >>> shared/tcm_pkg.sv
/*
 * Timer channel constants and types.
 * Assumes an 8-bit port.
 */
`default_nettype none

package tcm_pkg;

    // ********************************************************
    // Widths
    // ********************************************************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int CNT_W  = 16;

    // ********************************************************
    // Register offsets
    // ********************************************************
    localparam logic [7:0] OFF_TSC     = 8'h00;
    localparam logic [7:0] OFF_CNT_H   = 8'h01;
    localparam logic [7:0] OFF_CNT_L   = 8'h02;
    localparam logic [7:0] OFF_MOD_H   = 8'h03;
    localparam logic [7:0] OFF_MOD_L   = 8'h04;
    localparam logic [7:0] OFF_CH_BASE = 8'h05;
    localparam logic [7:0] CH_STRIDE   = 8'h03;
    localparam logic [7:0] CH_SUB_SC   = 8'h00;
    localparam logic [7:0] CH_SUB_VH   = 8'h01;
    localparam logic [7:0] CH_SUB_VL   = 8'h02;

    // ********************************************************
    // Field positions
    // ********************************************************
    localparam int TSC_FLAG_BIT = 7;
    localparam int TSC_CPWM_BIT = 5;
    localparam int TSC_RUN_BIT  = 3;
    localparam int CSC_FLAG_BIT = 7;
    localparam int CSC_MS_LSB   = 4;
    localparam int CSC_EL_LSB   = 2;

    // ********************************************************
    // Reset values and field codes
    // ********************************************************
    localparam logic [15:0] CNT_RST = 16'h0000;
    localparam logic [15:0] MOD_RST = 16'h0000;
    localparam logic [15:0] VAL_RST = 16'h0000;
    localparam logic [1:0]  EL_OFF  = 2'h0;
    localparam logic [1:0]  EL_RISE = 2'h1;
    localparam logic [1:0]  EL_FALL = 2'h2;
    localparam logic [1:0]  EL_BOTH = 2'h3;
    localparam logic [1:0]  MS_CAP  = 2'h0;
    localparam logic [1:0]  MS_CMP  = 2'h1;

    // ********************************************************
    // Types
    // ********************************************************
    typedef enum logic [2:0] {
        TCM_OFF  = 3'b000,
        TCM_CAP  = 3'b001,
        TCM_CMP  = 3'b011,
        TCM_EPWM = 3'b010,
        TCM_CPWM = 3'b110
    } tcm_mode_e;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } tcm_bus_req_s;

    typedef struct packed {
        logic [1:0] channel_mode_field;
        logic [1:0] edge_level_field;
    } tcm_ch_cfg_s;

    // Center select wins; high mode bit picks edge PWM
    function automatic tcm_mode_e tcm_decode(input logic cpwm, input tcm_ch_cfg_s cfg);
        tcm_mode_e m;
        m = TCM_OFF;
        if (cpwm) begin
            m = TCM_CPWM;
        end else if (cfg.channel_mode_field[1]) begin
            m = TCM_EPWM;
        end else if (cfg.channel_mode_field == MS_CAP) begin
            m = TCM_CAP;
        end else begin
            m = TCM_CMP;
        end
        return m;
    endfunction

endpackage

`default_nettype wire

// >>> rtl/tcm_pin_sync.sv
/*
 * Two-flop pin synchroniser with edge pulses.
 * Assumes async pins.
 */
`timescale 1ns/10ps
`default_nettype none

module tcm_pin_sync #(
    parameter int WIDTH = 2
) (
    input  wire logic             core_clk_in,
    input  wire logic             rst_n_in,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] rise_out,
    output logic      [WIDTH-1:0] fall_out
);

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;
    logic [WIDTH-1:0] hist_reg;
    logic [WIDTH-1:0] rise_reg;
    logic [WIDTH-1:0] fall_reg;
    logic [WIDTH-1:0] rise_next;
    logic [WIDTH-1:0] fall_next;

    // Edges never read the first stage
    always_comb begin
        rise_next = sync_reg & ~hist_reg;
        fall_next = ~sync_reg & hist_reg;
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta_reg <= '0;
            sync_reg <= '0;
            hist_reg <= '0;
            rise_reg <= '0;
            fall_reg <= '0;
        end else begin
            meta_reg <= pin_in;
            sync_reg <= meta_reg;
            hist_reg <= sync_reg;
            rise_reg <= rise_next;
            fall_reg <= fall_next;
        end
    end

    assign rise_out = rise_reg;
    assign fall_out = fall_reg;

endmodule

`default_nettype wire

// >>> rtl/tcm_timer.sv
/*
 * Timer with counter, modulo and channels.
 * compare and PWM logic behind an 8-bit register port.
 * Assumes one clock, async pins.
 */
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// RULE1 - Edge/level 00 releases the pin entirely
// RULE2 - Capture mode, 01 captures rising edges
// RULE3 - Capture mode, 10 captures falling edges
// RULE4 - Capture mode, 11 captures both edges
// RULE5 - Compare: 00 flags only, 01 toggles
// RULE6 - Compare with 10 drives pin low
// RULE7 - Compare with 11 drives pin high
// RULE8 - Edge PWM 10: high-true, clear on match
// RULE9 - Edge PWM X1: low-true, set on match
// RULE10 - Center PWM overrides mode; 10 high-true
// RULE11 - Center PWM X1: low-true, set up-match
// RULE12 - Pin stable two clocks before capture
// RULE13 - Software clears flags after reconfiguring
// RULE14 - Capture loads counter into value register
// RULE15 - Value register holds readable compare value
// RULE16 - Value register resets to zero
// RULE17 - Timer and channel register set provided
// RULE18 - Edge PWM value buffered until counter zero
// RULE19 - Center PWM flags both matches
// RULE20 - Mode high bit alone selects edge PWM
module tcm_timer
    import tcm_pkg::*;
#(
    parameter int NUM_CH = 2
) (
    input  wire logic                  core_clk_in,
    input  wire logic                  rst_n_in,
    input  wire tcm_pkg::tcm_bus_req_s bus_req_in,
    output logic [tcm_pkg::DATA_W-1:0] rd_data_out,
    input  wire logic [NUM_CH-1:0]     chan_pin_in,
    output logic [NUM_CH-1:0]          chan_pin_out,
    output logic [NUM_CH-1:0]          chan_pin_oe_out
);

    // ********************************************************
    // Timer state
    // ********************************************************
    logic [15:0] cnt_reg;
    logic [15:0] cnt_next;
    logic [15:0] mod_reg;
    logic [15:0] mod_next;
    logic [7:0]  mod_hi_reg;
    logic [7:0]  mod_hi_next;
    logic        up_reg;
    logic        up_next;
    logic        run_reg;
    logic        run_next;
    logic        cpwm_reg;
    logic        cpwm_next;
    logic        tof_reg;
    logic        tof_next;
    logic        tof_arm_reg;
    logic        tof_arm_next;
    logic [7:0]  rd_data_reg;
    logic [7:0]  rd_data_next;

    logic [NUM_CH-1:0] rise;
    logic [NUM_CH-1:0] fall;
    logic [7:0]        ch_rd [NUM_CH];
    logic [NUM_CH-1:0] pin_q;
    logic [NUM_CH-1:0] oe_q;

    logic wr_tsc;
    logic rd_tsc;
    logic at_zero;

    assign wr_tsc  = bus_req_in.wr && (bus_req_in.addr == OFF_TSC);
    assign rd_tsc  = bus_req_in.rd && (bus_req_in.addr == OFF_TSC);
    assign at_zero = run_reg && (cnt_reg == 16'h0000);

    // RULE12 pin synchroniser
    // Moving pin may flag early
    tcm_pin_sync #(
        .WIDTH (NUM_CH)
    ) u_sync (
        .core_clk_in (core_clk_in),
        .rst_n_in    (rst_n_in),
        .pin_in      (chan_pin_in),
        .rise_out    (rise),
        .fall_out    (fall)
    );

    // ********************************************************
    // Counter and timer status/control
    // ********************************************************
    always_comb begin
        cnt_next     = cnt_reg;
        up_next      = up_reg;
        mod_next     = mod_reg;
        mod_hi_next  = mod_hi_reg;
        run_next     = run_reg;
        cpwm_next    = cpwm_reg;
        tof_next     = tof_reg;
        tof_arm_next = tof_arm_reg;
        if (run_reg) begin
            if (cpwm_reg) begin
                // Zero modulo parks the counter
                if (mod_reg == 16'h0000) begin
                    cnt_next = 16'h0000;
                end else if (up_reg) begin
                    if (cnt_reg >= mod_reg) begin
                        up_next  = 1'b0;
                        cnt_next = cnt_reg - 16'h0001;
                    end else begin
                        cnt_next = cnt_reg + 16'h0001;
                    end
                end else if (cnt_reg == 16'h0000) begin
                    up_next  = 1'b1;
                    cnt_next = 16'h0001;
                    tof_next = 1'b1;
                end else begin
                    cnt_next = cnt_reg - 16'h0001;
                end
            end else begin
                if ((cnt_reg == mod_reg && mod_reg != 16'h0000) || cnt_reg == 16'hFFFF) begin
                    cnt_next = 16'h0000;
                    tof_next = 1'b1;
                end else begin
                    cnt_next = cnt_reg + 16'h0001;
                end
            end
        end
        // RULE17 timer registers
        if (wr_tsc) begin
            cpwm_next    = bus_req_in.wdata[TSC_CPWM_BIT];
            run_next     = bus_req_in.wdata[TSC_RUN_BIT];
            tof_arm_next = 1'b0;
            if (tof_arm_reg && !bus_req_in.wdata[TSC_FLAG_BIT]) begin
                tof_next = 1'b0;
            end
        end
        if (rd_tsc && tof_reg) begin
            tof_arm_next = 1'b1;
        end
        // Up-count overflow set beats clear
        if (run_reg && !cpwm_reg && cnt_next == 16'h0000 && cnt_reg != 16'h0000) begin
            tof_next = 1'b1;
        end
        if (bus_req_in.wr && (bus_req_in.addr == OFF_CNT_H || bus_req_in.addr == OFF_CNT_L)) begin
            cnt_next = CNT_RST;
            up_next  = 1'b1;
        end
        // High byte waits for low: coherent update
        if (bus_req_in.wr && bus_req_in.addr == OFF_MOD_H) begin
            mod_hi_next = bus_req_in.wdata;
        end
        if (bus_req_in.wr && bus_req_in.addr == OFF_MOD_L) begin
            mod_next = {mod_hi_reg, bus_req_in.wdata};
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_reg     <= CNT_RST;
            mod_reg     <= MOD_RST;
            mod_hi_reg  <= 8'h00;
            up_reg      <= 1'b1;
            run_reg     <= 1'b0;
            cpwm_reg    <= 1'b0;
            tof_reg     <= 1'b0;
            tof_arm_reg <= 1'b0;
        end else begin
            cnt_reg     <= cnt_next;
            mod_reg     <= mod_next;
            mod_hi_reg  <= mod_hi_next;
            up_reg      <= up_next;
            run_reg     <= run_next;
            cpwm_reg    <= cpwm_next;
            tof_reg     <= tof_next;
            tof_arm_reg <= tof_arm_next;
        end
    end

    // ********************************************************
    // Channels
    // ********************************************************
    for (genvar i = 0; i < NUM_CH; i++) begin : gen_ch
        localparam logic [7:0] CH_OFF = 8'(OFF_CH_BASE + CH_STRIDE * i);

        tcm_ch_cfg_s cfg_reg;
        tcm_ch_cfg_s cfg_next;
        logic [15:0] val_reg;
        logic [15:0] val_next;
        logic [15:0] buf_reg;
        logic [15:0] buf_next;
        logic        hi_reg;
        logic        hi_next;
        logic        lo_reg;
        logic        lo_next;
        logic        flag_reg;
        logic        flag_next;
        logic        arm_reg;
        logic        arm_next;
        logic        pin_reg;
        logic        pin_next;
        logic        oe_reg;
        logic        oe_next;
        tcm_mode_e   mode;
        logic        match;
        logic        edge_hit;
        logic        pwm;

        always_comb begin
            cfg_next  = cfg_reg;
            val_next  = val_reg;
            buf_next  = buf_reg;
            hi_next   = hi_reg;
            lo_next   = lo_reg;
            flag_next = flag_reg;
            arm_next  = arm_reg;
            pin_next  = pin_reg;
            oe_next   = 1'b0;
            // RULE20 mode decode
            mode  = tcm_decode(cpwm_reg, cfg_reg);
            pwm   = (mode == TCM_EPWM) || (mode == TCM_CPWM);
            match = run_reg && (cnt_reg == val_reg);
            // RULE2 rising edge select
            // RULE3 falling edge select
            // RULE4 both edge select
            edge_hit = (rise[i] && cfg_reg.edge_level_field[0])
                     || (fall[i] && cfg_reg.edge_level_field[1]);

            // RULE18 buffered value transfer
            if (hi_reg && lo_reg && (!pwm || at_zero)) begin
                val_next = buf_reg;
                hi_next  = 1'b0;
                lo_next  = 1'b0;
            end

            // RULE13 two-step flag clear
            if (bus_req_in.wr && bus_req_in.addr == CH_OFF + CH_SUB_SC) begin
                cfg_next.channel_mode_field = bus_req_in.wdata[CSC_MS_LSB +: 2];
                cfg_next.edge_level_field   = bus_req_in.wdata[CSC_EL_LSB +: 2];
                arm_next = 1'b0;
                if (arm_reg && !bus_req_in.wdata[CSC_FLAG_BIT]) begin
                    flag_next = 1'b0;
                end
            end
            if (bus_req_in.rd && bus_req_in.addr == CH_OFF + CH_SUB_SC && flag_reg) begin
                arm_next = 1'b1;
            end
            // RULE15 compare value written by software
            if (bus_req_in.wr && bus_req_in.addr == CH_OFF + CH_SUB_VH) begin
                buf_next[15:8] = bus_req_in.wdata;
                hi_next        = 1'b1;
            end
            if (bus_req_in.wr && bus_req_in.addr == CH_OFF + CH_SUB_VL) begin
                buf_next[7:0] = bus_req_in.wdata;
                lo_next       = 1'b1;
            end

            // Events last: set beats clear
            unique case (mode)
                TCM_CAP: begin
                    // RULE14 capture counter on edge
                    if (edge_hit) begin
                        val_next  = cnt_reg;
                        flag_next = 1'b1;
                    end
                end
                TCM_CMP: begin
                    // RULE5 flag and toggle
                    // RULE6 clear on match
                    // RULE7 set on match
                    oe_next = (cfg_reg.edge_level_field != EL_OFF);
                    if (match) begin
                        flag_next = 1'b1;
                        unique case (cfg_reg.edge_level_field)
                            EL_OFF:  pin_next = pin_reg;
                            EL_RISE: pin_next = ~pin_reg;
                            EL_FALL: pin_next = 1'b0;
                            EL_BOTH: pin_next = 1'b1;
                        endcase
                    end
                end
                TCM_EPWM: begin
                    // RULE8 high-true edge PWM
                    // RULE9 low-true edge PWM
                    oe_next = (cfg_reg.edge_level_field != EL_OFF);
                    if (at_zero) begin
                        pin_next = ~cfg_reg.edge_level_field[0];
                    end
                    // Match last: zero value gives 0%
                    if (match) begin
                        pin_next  = cfg_reg.edge_level_field[0];
                        flag_next = 1'b1;
                    end
                end
                TCM_CPWM: begin
                    // RULE10 high-true center PWM
                    // RULE11 low-true center PWM
                    // RULE19 flag at both matches
                    oe_next = (cfg_reg.edge_level_field != EL_OFF);
                    if (match) begin
                        pin_next  = up_reg ? cfg_reg.edge_level_field[0]
                                           : ~cfg_reg.edge_level_field[0];
                        flag_next = 1'b1;
                    end
                    // Zero or negative value never reaches the active level
                    if (val_reg == 16'h0000 || val_reg[15]) begin
                        pin_next = cfg_reg.edge_level_field[0];
                    end
                end
                default: begin
                    oe_next = 1'b0;
                end
            endcase

            // RULE1 pin released
            if (cfg_reg.edge_level_field == EL_OFF) begin
                oe_next = 1'b0;
            end
        end

        always_ff @(posedge core_clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
                cfg_reg  <= '0;
                // RULE16 value cleared by reset
                val_reg  <= VAL_RST;
                buf_reg  <= VAL_RST;
                hi_reg   <= 1'b0;
                lo_reg   <= 1'b0;
                flag_reg <= 1'b0;
                arm_reg  <= 1'b0;
                pin_reg  <= 1'b0;
                oe_reg   <= 1'b0;
            end else begin
                cfg_reg  <= cfg_next;
                val_reg  <= val_next;
                buf_reg  <= buf_next;
                hi_reg   <= hi_next;
                lo_reg   <= lo_next;
                flag_reg <= flag_next;
                arm_reg  <= arm_next;
                pin_reg  <= pin_next;
                oe_reg   <= oe_next;
            end
        end

        // RULE17 channel read data
        always_comb begin
            ch_rd[i] = 8'h00;
            if (bus_req_in.addr == CH_OFF + CH_SUB_SC) begin
                ch_rd[i] = {flag_reg, 1'b0, cfg_reg.channel_mode_field,
                            cfg_reg.edge_level_field, 2'h0};
            end else if (bus_req_in.addr == CH_OFF + CH_SUB_VH) begin
                ch_rd[i] = val_reg[15:8];
            end else if (bus_req_in.addr == CH_OFF + CH_SUB_VL) begin
                ch_rd[i] = val_reg[7:0];
            end
        end

        assign pin_q[i] = pin_reg;
        assign oe_q[i]  = oe_reg;
    end

    // ********************************************************
    // Read port
    // ********************************************************
    always_comb begin
        rd_data_next = 8'h00;
        if (bus_req_in.rd) begin
            unique case (bus_req_in.addr)
                OFF_TSC:   rd_data_next = {tof_reg, 1'b0, cpwm_reg, 1'b0, run_reg, 3'h0};
                OFF_CNT_H: rd_data_next = cnt_reg[15:8];
                OFF_CNT_L: rd_data_next = cnt_reg[7:0];
                OFF_MOD_H: rd_data_next = mod_reg[15:8];
                OFF_MOD_L: rd_data_next = mod_reg[7:0];
                default: begin
                    for (int k = 0; k < NUM_CH; k++) begin
                        rd_data_next = rd_data_next | ch_rd[k];
                    end
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rd_data_reg <= 8'h00;
        end else begin
            rd_data_reg <= rd_data_next;
        end
    end

    assign rd_data_out     = rd_data_reg;
    assign chan_pin_out    = pin_q;
    assign chan_pin_oe_out = oe_q;

endmodule

`default_nettype wire

// >>> dv/tcm_timer_checker.sv
/*
 * Checker on tcm_timer ports.
 * Assumes every bus write lands.
 */
`timescale 1ns/10ps
`default_nettype none

module tcm_timer_checker
    import tcm_pkg::*;
#(
    parameter int NUM_CH = 2
) (
    input wire logic                       core_clk_in,
    input wire logic                       rst_n_in,
    input wire tcm_pkg::tcm_bus_req_s      bus_req_in,
    input wire logic [tcm_pkg::DATA_W-1:0] rd_data_out,
    input wire logic [NUM_CH-1:0]          chan_pin_in,
    input wire logic [NUM_CH-1:0]          chan_pin_out,
    input wire logic [NUM_CH-1:0]          chan_pin_oe_out
);
    // ****************
    // Config shadow
    // ****************
    // Age since config write covers oe lag
    logic       cpwm_reg, cpwm_next;
    logic [3:0] cfg_reg, cfg_next;
    logic [1:0] age_reg, age_next;
    always_comb begin
        cpwm_next = cpwm_reg;
        cfg_next = cfg_reg;
        age_next = (age_reg == 2'h3) ? age_reg : age_reg + 2'h1;
        if (bus_req_in.wr && bus_req_in.addr == OFF_TSC) begin
            cpwm_next = bus_req_in.wdata[TSC_CPWM_BIT];
            age_next = 2'h0;
        end
        if (bus_req_in.wr && bus_req_in.addr == OFF_CH_BASE) begin
            cfg_next = bus_req_in.wdata[5:2];
            age_next = 2'h0;
        end
    end
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cpwm_reg <= 1'b0;
            cfg_reg <= 4'h0;
            age_reg <= 2'h3;
        end else begin
            cpwm_reg <= cpwm_next;
            cfg_reg <= cfg_next;
            age_reg <= age_next;
        end
    end

    // ****************
    // Assertions
    // ****************
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);
    rd_idle_zero_a: assert property (!$past(bus_req_in.rd) |-> rd_data_out == 8'h00)
        else $error("stray read data");
    reset_quiet_a: assert property (!$past(rst_n_in) |-> chan_pin_oe_out == '0)
        else $error("drive after reset");
    el_off_a: assert property (age_reg != 2'h0 && cfg_reg[1:0] == EL_OFF |-> !chan_pin_oe_out[0])
        else $error("drive when off");
    cap_release_a: assert property (age_reg != 2'h0 && !cpwm_reg && cfg_reg[3:2] == MS_CAP
        |-> !chan_pin_oe_out[0])
        else $error("drive in capture");
    drive_on_a: assert property (age_reg != 2'h0 && !cpwm_reg && cfg_reg[3:2] != MS_CAP
        && cfg_reg[1:0] != EL_OFF |-> chan_pin_oe_out[0])
        else $error("no compare drive");
    cpwm_drive_a: assert property (age_reg != 2'h0 && cpwm_reg && cfg_reg[1:0] != EL_OFF
        |-> chan_pin_oe_out[0])
        else $error("no center drive");
    clr_only_a: assert property (age_reg == 2'h3 && !cpwm_reg && cfg_reg == {MS_CMP, EL_FALL}
        && $past(chan_pin_oe_out[0]) |-> !$rose(chan_pin_out[0]))
        else $error("rise in clear");
    set_only_a: assert property (age_reg == 2'h3 && !cpwm_reg && cfg_reg == {MS_CMP, EL_BOTH}
        && $past(chan_pin_oe_out[0]) |-> !$fell(chan_pin_out[0]))
        else $error("fall in set");
endmodule

bind tcm_timer tcm_timer_checker #(.NUM_CH(NUM_CH)) tcm_timer_checker_inst (
    .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .bus_req_in(bus_req_in),
    .rd_data_out(rd_data_out), .chan_pin_in(chan_pin_in), .chan_pin_out(chan_pin_out),
    .chan_pin_oe_out(chan_pin_oe_out));

`default_nettype wire

// >>> dv/tcm_pin_load.sv
/*
 * Far side of the channel pins.
 * Assumes the bench holds the outside level.
 */
`timescale 1ns/10ps
`default_nettype none

module tcm_pin_load #(
    parameter int NUM_CH = 2
) (
    input  wire logic [NUM_CH-1:0] ext_lvl_in,
    input  wire logic [NUM_CH-1:0] pin_drv_in,
    input  wire logic [NUM_CH-1:0] pin_oe_in,
    output logic      [NUM_CH-1:0] pin_out
);
    // steady outside source
    // Driver wins when enabled
    always_comb begin
        pin_out = (pin_oe_in & pin_drv_in) | (~pin_oe_in & ext_lvl_in);
    end
endmodule

`default_nettype wire

// >>> dv/tcm_timer_tb_top.sv
/*
 * Bench for tcm_timer.
 * Assumes the pin load model and the bound checker.
 */
`timescale 1ns/10ps
`default_nettype none

module tcm_timer_tb_top;
    import tcm_pkg::*;
    logic         core_clk_in = 1'b0;
    logic         rst_n_in    = 1'b0;
    tcm_bus_req_s req         = '0;
    logic [7:0]   rdata;
    logic [1:0]   pin, pout, poe;
    logic [1:0]   ext_lvl     = 2'b00;
    logic [1:0]   el, ms;
    logic [15:0]  val, seen;
    logic         p0;
    int           n_fail      = 0;
    int           n_checks    = 0;
    int           hi;
    always #5 core_clk_in = ~core_clk_in;
    tcm_timer #(.NUM_CH(2)) tcm_timer_inst (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
        .bus_req_in(req), .rd_data_out(rdata), .chan_pin_in(pin), .chan_pin_out(pout),
        .chan_pin_oe_out(poe));
    tcm_pin_load #(.NUM_CH(2)) tcm_pin_load_inst (.ext_lvl_in(ext_lvl), .pin_drv_in(pout),
        .pin_oe_in(poe), .pin_out(pin));

    // ****************
    // Helpers
    // ****************
    function automatic logic [7:0] sc(input int n);
        return 8'(OFF_CH_BASE + CH_STRIDE * n);
    endfunction
    function automatic logic [15:0] high_cycles(input int h, input int per, input logic el0);
        h = (h > per) ? per : h;
        return 16'(el0 ? per - h : h);
    endfunction
    task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk_in);
        req <= '{1'b1, 1'b0, a, d};
        @(posedge core_clk_in);
        req <= '0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk_in);
        req <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge core_clk_in);
        req <= '0;
        #1 d = rdata;
    endtask
    task automatic wr16(input logic [7:0] a, input logic [15:0] v);
        wr(a, v[15:8]);
        wr(a + 8'h01, v[7:0]);
    endtask
    task automatic rd16(input logic [7:0] a, output logic [15:0] v);
        rd(a, v[15:8]);
        rd(a + 8'h01, v[7:0]);
    endtask
    task automatic count_high(input int n, input int wait_n, output int h);
        h = 0;
        repeat (wait_n) @(posedge core_clk_in);
        repeat (n) begin
            @(posedge core_clk_in);
            #1 h += int'(pout[0]);
        end
    endtask
    task automatic report_and_stop();
        if (n_fail == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ****************
    // Tests
    // ****************
    initial begin
        #100us;
        n_fail++;
        report_and_stop();
    end
    initial begin
        void'($urandom(32'h87948D0A));
        repeat (20) @(posedge core_clk_in);
        rst_n_in <= 1'b1;
        for (int c = 0; c < 2; c++) begin
            rd16(sc(c) + CH_SUB_VH, seen);
            check("value after reset", seen, VAL_RST);
        end
        rd(8'hFF, seen[7:0]);
        check("unmapped read", seen[7:0], 16'h0000);
        // Counter parked, so capture loads zero
        for (int e = 0; e < 4; e++) begin
            for (int r = 0; r < 2; r++) begin
                ext_lvl <= {~r[0], 1'b0};
                repeat (4) @(posedge core_clk_in);
                wr(sc(1), {2'b00, MS_CAP, 2'(e), 2'b00});
                val = 16'($urandom_range(1, 16'hFFFF));
                wr16(sc(1) + CH_SUB_VH, val);
                repeat (3) @(posedge core_clk_in);
                ext_lvl <= {r[0], 1'b0};
                repeat (8) @(posedge core_clk_in);
                rd16(sc(1) + CH_SUB_VH, seen);
                check("capture value", seen, ((e == 3) || (e == 1 && r == 1) || (e == 2 && r == 0))
                    ? CNT_RST : val);
            end
        end
        wr16(sc(0) + CH_SUB_VH, 16'h0004);
        rd16(sc(0) + CH_SUB_VH, seen);
        check("readback", seen, 16'h0004);
        wr16(OFF_MOD_H, 16'h0009);
        wr(OFF_TSC, 8'h08);
        for (int e = 1; e < 4; e++) begin
            wr(sc(0), {2'b00, MS_CMP, 2'(e), 2'b00});
            repeat (25) @(posedge core_clk_in);
            #1 p0 = pout[0];
            repeat (10) @(posedge core_clk_in);
            #1 check("compare pin", pout[0], (e == 1) ? !p0 : (e == 3));
        end
        // Covers 0 and 100 percent ends
        for (int k = 0; k < 6; k++) begin
            val = (k == 0) ? 16'h0000 : (k == 1) ? 16'h000C : 16'($urandom_range(1, 8));
            el = k[0] ? (k[1] ? EL_BOTH : EL_RISE) : EL_FALL;
            ms = k[2] ? 2'b11 : 2'b10;
            wr(sc(0), {2'b00, ms, el, 2'b00});
            wr16(sc(0) + CH_SUB_VH, val);
            count_high(10, 30, hi);
            check("epwm high", 16'(hi), high_cycles(int'(val), 10, el[0]));
        end
        wr(sc(0), 8'h28);
        wr16(sc(0) + CH_SUB_VH, 16'h0005);
        repeat (30) @(posedge core_clk_in);
        wr(sc(0) + CH_SUB_VL, 8'h02);
        count_high(10, 30, hi);
        check("half write", 16'(hi), 16'h0005);
        wr(OFF_TSC, 8'h28);
        for (int k = 0; k < 4; k++) begin
            val = 16'($urandom_range(1, 8));
            el = k[0] ? EL_RISE : EL_FALL;
            wr(sc(0), {2'b00, k[1], 1'b0, el, 2'b00});
            wr16(sc(0) + CH_SUB_VH, val);
            count_high(18, 50, hi);
            check("cpwm high", 16'(hi), high_cycles(2 * int'(val), 18, el[0]));
        end
        report_and_stop();
    end
endmodule

`default_nettype wire
